// File: rtl/cxe_endian_lanes.sv
/*
  byte lane steering for byte and halfword accesses, one cycle registered.
  assumes the address low bits and size belong to the same access.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cxe_params.svh"
module cxe_endian_lanes (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // access
  input wire logic bigEndian,
  input wire cxe_pkg::cxe_size_t accSize,
  input wire logic [1:0] addrLow,
  input wire logic [31:0] storeData,
  input wire logic [31:0] busData,
  // steered data
  output logic [3:0] laneEn,
  output logic [31:0] busStoreData,
  output logic [31:0] loadData
);
  import cxe_pkg::*;

  typedef struct packed {
    logic [3:0] laneEn;
    logic [31:0] busStoreData;
    logic [31:0] loadData;
  } cxe_lane_state_t;

  cxe_lane_state_t s;
  cxe_lane_state_t next_s;
  logic [1:0] lane;

  // lowest numbered lane that the access occupies
  function automatic logic [1:0] laneOf(input logic be, input logic [1:0] a,
                                        input cxe_size_t sz);
    if (sz == SZ_HALF) return be ? {~a[1], 1'b0} : {a[1], 1'b0};
    return be ? ~a : a;
  endfunction

  // words and fetches pass straight, so the setting cannot disturb code
  always_comb begin
    next_s = s;
    lane = laneOf(bigEndian, addrLow, accSize);
    unique case (accSize)
      SZ_BYTE: begin
        next_s.laneEn = 4'h1 << lane;
        next_s.busStoreData = {4{storeData[7:0]}};
        next_s.loadData = {24'h000000, 8'(busData >> {lane, 3'b000})};
      end
      SZ_HALF: begin
        next_s.laneEn = 4'h3 << lane;
        next_s.busStoreData = {2{storeData[15:0]}};
        next_s.loadData = {16'h0000, 16'(busData >> {lane, 3'b000})};
      end
      SZ_WORD, SZ_FETCH: begin
        next_s.laneEn = 4'hF;
        next_s.busStoreData = storeData;
        next_s.loadData = busData;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign laneEn = s.laneEn;
  assign busStoreData = s.busStoreData;
  assign loadData = s.loadData;

  property p_le_byte0;
    @(posedge clk_sys) disable iff (!rst_n)
    (accSize == SZ_BYTE && !bigEndian && addrLow == 2'h0) |=> laneEn == 4'h1;
  endproperty
  a_le_byte0: assert property (p_le_byte0) else $error("le byte 0 off lane 0");

  property p_be_byte0;
    @(posedge clk_sys) disable iff (!rst_n)
    (accSize == SZ_BYTE && bigEndian && addrLow == 2'h0) |=>
      laneEn == 4'h8 && loadData[7:0] == $past(busData[31:24]);
  endproperty
  a_be_byte0: assert property (p_be_byte0) else $error("be byte 0 off lane 3");

  property p_word_flat;
    @(posedge clk_sys) disable iff (!rst_n)
    (accSize == SZ_WORD || accSize == SZ_FETCH) |=>
      loadData == $past(busData) && laneEn == 4'hF;
  endproperty
  a_word_flat: assert property (p_word_flat) else $error("word access was steered");
endmodule
`default_nettype wire

// File: rtl/cxe_exception_entry.sv
/*
  exception entry unit: reset entry, abort sampling and suppression,
  priority selection, status and link saving, vector fetch, control bits
  and byte lane steering.
  assumes the pipeline reports fetch and execute slots and the banked
  register file stores linkValue and savedValue under entryMode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cxe_params.svh"
module cxe_exception_entry #(
  parameter int SLOTS = 4,
  parameter int SLOT_W = $clog2(SLOTS)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // memory access and abort sources
  input wire logic memCycle,
  input wire logic memIsFetch,
  input wire logic mmuAbort,
  input wire logic extAbort,
  input wire logic [31:0] memInstrAddr,
  input wire cxe_pkg::cxe_xfer_t xferKind,
  input wire logic xferWriteback,
  input wire logic baseInList,
  // pipeline
  input wire logic fetchValid,
  input wire logic [SLOT_W-1:0] fetchSlot,
  input wire logic execValid,
  input wire logic [SLOT_W-1:0] execSlot,
  input wire logic [31:0] execAddr,
  input wire logic flush,
  // decode
  input wire logic undefDecode,
  input wire logic swiDecode,
  input wire logic coprocInstr,
  input wire logic coprocRegXfer,
  input wire logic [3:0] coprocNum,
  // interrupts
  input wire logic fastInterrupt,
  input wire logic normalInterrupt,
  // software writes
  input wire logic statusWrEn,
  input wire logic [31:0] statusWrData,
  input wire logic ctrlWrEn,
  input wire logic [`CXE_CTRL_W-1:0] ctrlWrData,
  // byte lanes
  input wire cxe_pkg::cxe_size_t accSize,
  input wire logic [1:0] addrLow,
  input wire logic [31:0] storeData,
  input wire logic [31:0] busData,
  output logic [3:0] laneEn,
  output logic [31:0] busStoreData,
  output logic [31:0] loadData,
  // reset and bus state
  output logic systemResetLowOut,
  output logic execHalt,
  output logic busIdle,
  // abort suppression
  output logic cancelRegWrite,
  output logic cancelBaseWb,
  output logic restoreBase,
  output logic stopXfer,
  // entry
  output logic vectorFetch,
  output logic [31:0] vectorAddr,
  output logic linkWrite,
  output logic [31:0] linkValue,
  output logic [31:0] savedValue,
  output logic [4:0] entryMode,
  output logic [31:0] currentStatusWord,
  // control
  output logic mmuEnable,
  output logic alignEnable,
  output logic dcacheEnable,
  output logic wbufEnable,
  output logic icacheEnable,
  output logic bigEndian
);
  import cxe_pkg::*;

  typedef struct packed {
    cxe_state_t state;
    logic [31:0] currentStatus;
    logic [`CXE_CTRL_W-1:0] ctrl;
    logic [SLOTS-1:0] marks;
    logic sysResetLowOut;
    logic vectorFetch;
    logic [31:0] vectorAddr;
    logic linkWrite;
    logic [31:0] linkValue;
    logic [31:0] savedValue;
    logic [4:0] entryMode;
  } cxe_core_state_t;

  cxe_core_state_t s;
  cxe_core_state_t next_s;
  logic abortSeen;
  logic pabtFetch;
  logic dabtReq;
  logic pabtReq;
  logic cpTrap;
  logic undefReq;
  logic swiReq;
  logic fiqReq;
  logic irqReq;
  logic [`CXE_REQ_N-1:0] reqs;
  logic [`CXE_REQ_N-1:0] grant;
  cxe_kind_t kind;
  logic takeEntry;
  logic [31:0] linkBase;

  function automatic logic [31:0] vecOf(input cxe_kind_t k);
    unique case (k)
      KIND_RESET: return `CXE_VEC_RESET;
      KIND_DABT: return `CXE_VEC_DABT;
      KIND_FIQ: return `CXE_VEC_FIQ;
      KIND_IRQ: return `CXE_VEC_IRQ;
      KIND_PABT: return `CXE_VEC_PABT;
      KIND_UNDEF: return `CXE_VEC_UNDEF;
      KIND_SWI: return `CXE_VEC_SWI;
      default: return `CXE_VEC_RESET;
    endcase
  endfunction

  // every code has the 32-bit mode bit set
  function automatic logic [4:0] modeOf(input cxe_kind_t k);
    unique case (k)
      KIND_DABT, KIND_PABT: return `CXE_MODE_ABT;
      KIND_FIQ: return `CXE_MODE_FIQ;
      KIND_IRQ: return `CXE_MODE_IRQ;
      KIND_UNDEF: return `CXE_MODE_UND;
      default: return `CXE_MODE_SVC;
    endcase
  endfunction

  function automatic logic [31:0] linkOff(input cxe_kind_t k);
    unique case (k)
      KIND_DABT: return `CXE_LINK_DABT;
      KIND_PABT: return `CXE_LINK_PABT;
      default: return `CXE_LINK_OTHER;
    endcase
  endfunction

  // aborts only count inside a memory access cycle
  assign abortSeen = memCycle & (mmuAbort | extAbort);
  assign pabtFetch = abortSeen & memIsFetch;
  assign dabtReq = abortSeen & ~memIsFetch;
  // a marked instruction traps only when it reaches execution unflushed
  assign pabtReq = execValid & s.marks[execSlot] & ~flush;
  assign cpTrap = coprocInstr & ((coprocNum != `CXE_CP_SYS) | ~coprocRegXfer);
  assign undefReq = execValid & ~flush & (undefDecode | cpTrap);
  assign swiReq = execValid & ~flush & swiDecode & ~undefReq;
  assign fiqReq = fastInterrupt & ~s.currentStatus[`CXE_BIT_F];
  assign irqReq = normalInterrupt & ~s.currentStatus[`CXE_BIT_I];

  // request vector per state; entry and chain cycles take one source only
  always_comb begin
    reqs = '0;
    unique case (s.state)
      ST_ENTRY: reqs[`CXE_REQ_RESET] = 1'b1;
      ST_CHAIN: reqs[`CXE_REQ_FIQ] = 1'b1;
      ST_RUN: begin
        reqs[`CXE_REQ_DABT] = dabtReq;
        reqs[`CXE_REQ_FIQ] = fiqReq;
        reqs[`CXE_REQ_IRQ] = irqReq;
        reqs[`CXE_REQ_PABT] = pabtReq;
        reqs[`CXE_REQ_UNDEF] = undefReq;
        reqs[`CXE_REQ_SWI] = swiReq;
      end
    endcase
  end

  cxe_prio_sel u_cxe_prio_sel (
    .reqs(reqs),
    .kind(kind),
    .grant(grant)
  );

  assign takeEntry = (kind != KIND_NONE);

  // chained fiq returns into the data abort handler
  always_comb begin
    if (s.state == ST_CHAIN) begin
      linkBase = `CXE_VEC_DABT;
    end else if (kind == KIND_DABT) begin
      linkBase = memInstrAddr;
    end else begin
      linkBase = execAddr;
    end
  end

  // suppression of register effects of an aborted data access
  always_comb begin
    cancelRegWrite = dabtReq & (xferKind != XFER_MULTI);
    cancelBaseWb = dabtReq & xferWriteback;
    restoreBase = dabtReq & (xferKind == XFER_MULTI) & baseInList;
    stopXfer = dabtReq;
  end

  // next state of the whole unit
  always_comb begin
    next_s = s;
    next_s.vectorFetch = 1'b0;
    next_s.linkWrite = 1'b0;
    next_s.sysResetLowOut = 1'b1;
    if (flush) begin
      next_s.marks = '0;
    end
    if (fetchValid) begin
      next_s.marks[fetchSlot] = pabtFetch;
    end
    if (takeEntry) begin
      next_s.vectorFetch = 1'b1;
      next_s.vectorAddr = vecOf(kind);
      next_s.linkWrite = 1'b1;
      next_s.linkValue = linkBase + linkOff(kind);
      next_s.savedValue = s.currentStatus;
      next_s.entryMode = modeOf(kind);
      next_s.currentStatus[`CXE_MODE_MSB:`CXE_MODE_LSB] = modeOf(kind);
      next_s.currentStatus[`CXE_BIT_I] = 1'b1;
      if (kind == KIND_FIQ || kind == KIND_RESET) begin
        next_s.currentStatus[`CXE_BIT_F] = 1'b1;
      end
    end else if (statusWrEn && s.state == ST_RUN) begin
      next_s.currentStatus = statusWrData;
    end
    // writes wait until the reset entry is done, so reset values hold
    if (ctrlWrEn && s.state == ST_RUN) begin
      next_s.ctrl = ctrlWrData;
    end
    unique case (s.state)
      ST_ENTRY: next_s.state = ST_RUN;
      ST_RUN: begin
        if (kind == KIND_DABT && fiqReq) begin
          next_s.state = ST_CHAIN;
        end
      end
      ST_CHAIN: next_s.state = ST_RUN;
    endcase
  end

  // reset parks the unit in its entry state with control bits clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{state: ST_ENTRY, currentStatus: `CXE_STATUS_RST, ctrl: `CXE_CTRL_RST,
             marks: '0, sysResetLowOut: 1'b0, vectorFetch: 1'b0,
             vectorAddr: `CXE_VEC_RESET, linkWrite: 1'b0, linkValue: '0,
             savedValue: '0, entryMode: `CXE_MODE_SVC};
    end else begin
      s <= next_s;
    end
  end

  cxe_endian_lanes u_cxe_endian_lanes (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bigEndian(bigEndian),
    .accSize(accSize),
    .addrLow(addrLow),
    .storeData(storeData),
    .busData(busData),
    .laneEn(laneEn),
    .busStoreData(busStoreData),
    .loadData(loadData)
  );

  // halted and idle in reset and in the reset entry cycle
  assign execHalt = (s.state == ST_ENTRY);
  assign busIdle = (s.state == ST_ENTRY);
  assign systemResetLowOut = s.sysResetLowOut;
  assign vectorFetch = s.vectorFetch;
  assign vectorAddr = s.vectorAddr;
  assign linkWrite = s.linkWrite;
  assign linkValue = s.linkValue;
  assign savedValue = s.savedValue;
  assign entryMode = s.entryMode;
  assign currentStatusWord = s.currentStatus;
  assign mmuEnable = s.ctrl[`CXE_CTRL_MMU];
  assign alignEnable = s.ctrl[`CXE_CTRL_ALIGN];
  assign dcacheEnable = s.ctrl[`CXE_CTRL_DCACHE];
  assign wbufEnable = s.ctrl[`CXE_CTRL_WBUF];
  assign icacheEnable = s.ctrl[`CXE_CTRL_ICACHE];
  assign bigEndian = s.ctrl[`CXE_CTRL_BIGEND];

  property p_reset_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    !systemResetLowOut |-> busIdle && execHalt;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus busy in reset");

  property p_reset_entry;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(systemResetLowOut) |-> vectorFetch && vectorAddr == `CXE_VEC_RESET &&
      entryMode == `CXE_MODE_SVC && currentStatusWord[`CXE_BIT_I] &&
      currentStatusWord[`CXE_BIT_F];
  endproperty
  a_reset_entry: assert property (p_reset_entry) else $error("bad reset entry");

  property p_reset_ctrl;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(systemResetLowOut) |-> !mmuEnable && !alignEnable && !dcacheEnable &&
      !wbufEnable && !icacheEnable && !bigEndian;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not clear");

  property p_dabt_entry;
    @(posedge clk_sys) disable iff (!rst_n)
    kind == KIND_DABT |=> vectorFetch && vectorAddr == `CXE_VEC_DABT &&
      linkValue == $past(memInstrAddr) + `CXE_LINK_DABT && entryMode == `CXE_MODE_ABT;
  endproperty
  a_dabt_entry: assert property (p_dabt_entry) else $error("bad data abort entry");

  property p_pabt_entry;
    @(posedge clk_sys) disable iff (!rst_n)
    kind == KIND_PABT |=> vectorAddr == `CXE_VEC_PABT &&
      currentStatusWord[`CXE_BIT_I] && linkValue == $past(execAddr) + `CXE_LINK_PABT;
  endproperty
  a_pabt_entry: assert property (p_pabt_entry) else $error("bad prefetch abort");

  property p_chain;
    @(posedge clk_sys) disable iff (!rst_n)
    (kind == KIND_DABT && fiqReq) |=> vectorAddr == `CXE_VEC_DABT ##1
      vectorFetch && vectorAddr == `CXE_VEC_FIQ;
  endproperty
  a_chain: assert property (p_chain) else $error("fiq not chained");

  property p_prio;
    @(posedge clk_sys) disable iff (!rst_n)
    (s.state == ST_RUN && dabtReq) |-> kind == KIND_DABT;
  endproperty
  a_prio: assert property (p_prio) else $error("data abort lost priority");

  property p_flush;
    @(posedge clk_sys) disable iff (!rst_n)
    flush |-> kind != KIND_PABT;
  endproperty
  a_flush: assert property (p_flush) else $error("flushed fetch aborted");

  property p_cp_trap;
    @(posedge clk_sys) disable iff (!rst_n)
    (s.state == ST_RUN && execValid && !flush && coprocInstr &&
     coprocNum != `CXE_CP_SYS && !dabtReq && !fiqReq && !irqReq && !pabtReq)
      |-> kind == KIND_UNDEF;
  endproperty
  a_cp_trap: assert property (p_cp_trap) else $error("coprocessor not trapped");

  property p_one_grant;
    @(posedge clk_sys) disable iff (!rst_n)
    takeEntry |-> $onehot(grant);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("several grants");

  property p_mode32;
    @(posedge clk_sys) disable iff (!rst_n)
    vectorFetch |-> currentStatusWord[`CXE_MODE_32] && entryMode[`CXE_MODE_32];
  endproperty
  a_mode32: assert property (p_mode32) else $error("entry not in 32-bit mode");

  property p_suppress;
    @(posedge clk_sys) disable iff (!rst_n)
    dabtReq |-> stopXfer && (xferKind == XFER_MULTI ? (restoreBase == baseInList)
      : cancelRegWrite);
  endproperty
  a_suppress: assert property (p_suppress) else $error("abort not suppressed");
endmodule
`default_nettype wire

// File: rtl/cxe_prio_sel.sv
/*
  fixed priority selector over all exception requests of one cycle.
  assumes requests are indexed by the CXE_REQ_* positions.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cxe_params.svh"
module cxe_prio_sel (
  // requests
  input wire logic [`CXE_REQ_N-1:0] reqs,
  // selection
  output cxe_pkg::cxe_kind_t kind,
  output logic [`CXE_REQ_N-1:0] grant
);
  import cxe_pkg::*;

  // highest set request wins; undef and swi never coexist
  function automatic cxe_kind_t pickKind(input logic [`CXE_REQ_N-1:0] r);
    if (r[`CXE_REQ_RESET]) return KIND_RESET;
    if (r[`CXE_REQ_DABT]) return KIND_DABT;
    if (r[`CXE_REQ_FIQ]) return KIND_FIQ;
    if (r[`CXE_REQ_IRQ]) return KIND_IRQ;
    if (r[`CXE_REQ_PABT]) return KIND_PABT;
    if (r[`CXE_REQ_UNDEF]) return KIND_UNDEF;
    if (r[`CXE_REQ_SWI]) return KIND_SWI;
    return KIND_NONE;
  endfunction

  // grant keeps only the top request set
  always_comb begin
    kind = pickKind(reqs);
    grant = '0;
    for (int i = `CXE_REQ_N - 1; i >= 0; i--) begin
      if (reqs[i] && grant == '0) begin
        grant[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: shared/cxe_params.svh
/*
  constants of the exception entry and byte lane unit: mode codes,
  status bit positions, vectors, link offsets and control bits.
  assumes it is included by bare name by the package and the rtl files.
*/
`ifndef CXE_PARAMS_SVH
`define CXE_PARAMS_SVH
`define CXE_MODE_MSB 4
`define CXE_MODE_LSB 0
`define CXE_MODE_32 4
`define CXE_BIT_F 6
`define CXE_BIT_I 7
`define CXE_MODE_SVC 5'h13
`define CXE_MODE_ABT 5'h17
`define CXE_MODE_UND 5'h1B
`define CXE_MODE_IRQ 5'h12
`define CXE_MODE_FIQ 5'h11
`define CXE_VEC_RESET 32'h00000000
`define CXE_VEC_UNDEF 32'h00000004
`define CXE_VEC_SWI 32'h00000008
`define CXE_VEC_PABT 32'h0000000C
`define CXE_VEC_DABT 32'h00000010
`define CXE_VEC_IRQ 32'h00000018
`define CXE_VEC_FIQ 32'h0000001C
`define CXE_LINK_PABT 32'h00000004
`define CXE_LINK_DABT 32'h00000008
`define CXE_LINK_OTHER 32'h00000004
`define CXE_CP_SYS 4'hF
`define CXE_STATUS_RST 32'h000000D3
`define CXE_CTRL_W 16
`define CXE_CTRL_RST 16'h0000
`define CXE_CTRL_MMU 0
`define CXE_CTRL_ALIGN 1
`define CXE_CTRL_DCACHE 2
`define CXE_CTRL_WBUF 3
`define CXE_CTRL_BIGEND 7
`define CXE_CTRL_ICACHE 12
`define CXE_REQ_RESET 6
`define CXE_REQ_DABT 5
`define CXE_REQ_FIQ 4
`define CXE_REQ_IRQ 3
`define CXE_REQ_PABT 2
`define CXE_REQ_UNDEF 1
`define CXE_REQ_SWI 0
`define CXE_REQ_N 7
`endif

// File: shared/cxe_pkg.sv
/*
  types of the exception entry and byte lane unit.
  assumes cxe_params.svh is on the include path.
*/
`include "cxe_params.svh"
package cxe_pkg;
  // exception kinds after KIND_NONE, listed from highest to lowest priority
  typedef enum logic [2:0] {
    KIND_NONE, KIND_RESET, KIND_DABT, KIND_FIQ, KIND_IRQ, KIND_PABT, KIND_UNDEF, KIND_SWI
  } cxe_kind_t;
  typedef enum logic [1:0] {XFER_SINGLE, XFER_SWAP, XFER_MULTI} cxe_xfer_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_FETCH} cxe_size_t;
  typedef enum logic [1:0] {ST_ENTRY, ST_RUN, ST_CHAIN} cxe_state_t;
endpackage

// File: tb/cxe_exception_entry_test.sv
/*
  bench for the exception entry unit: reset, aborts, vectors, lanes.
  assumes cxe_pkg is compiled first and SLOTS keeps its default.
*/
`timescale 1ns/1ps
`default_nettype none
module cxe_exception_entry_test;
  import cxe_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic memCycle = 0, memIsFetch = 0, mmuAbort = 0, abortReq = 0, xferWriteback = 0;
  logic baseInList = 0, fetchValid = 0, execValid = 0, flush = 0, undefDecode = 0;
  logic swiDecode = 0, coprocInstr = 0, coprocRegXfer = 0, fastInterrupt = 0;
  logic normalInterrupt = 0, statusWrEn = 0, ctrlWrEn = 0;
  logic [1:0] fetchSlot = 0, execSlot = 0, addrLow = 0;
  logic [3:0] coprocNum = 0;
  logic [15:0] ctrlWrData = 0;
  logic [31:0] memInstrAddr = 0, execAddr = 0, statusWrData = 0, storeData = 0;
  cxe_xfer_t xferKind = XFER_SINGLE;
  cxe_size_t accSize = SZ_WORD;
  wire logic extAbort, systemResetLowOut, execHalt, busIdle, cancelRegWrite, cancelBaseWb;
  wire logic restoreBase, stopXfer, vectorFetch, linkWrite, mmuEnable, alignEnable;
  wire logic dcacheEnable, wbufEnable, icacheEnable, bigEndian;
  wire logic [3:0] laneEn;
  wire logic [4:0] entryMode;
  wire logic [31:0] busData, busStoreData, loadData, vectorAddr, linkValue, savedValue;
  wire logic [31:0] currentStatusWord;
  int mismatches = 0;
  int samples_checked = 0;

  always #2.5 clk_sys = ~clk_sys;

  cxe_mem_model u_cxe_mem_model (.clk_sys(clk_sys), .memCycle(memCycle),
    .abortReq(abortReq), .extAbort(extAbort), .busData(busData));

  cxe_exception_entry u_cxe_exception_entry (.clk_sys(clk_sys), .rst_n(rst_n),
    .memCycle(memCycle), .memIsFetch(memIsFetch), .mmuAbort(mmuAbort), .extAbort(extAbort),
    .memInstrAddr(memInstrAddr), .xferKind(xferKind), .xferWriteback(xferWriteback),
    .baseInList(baseInList), .fetchValid(fetchValid), .fetchSlot(fetchSlot),
    .execValid(execValid), .execSlot(execSlot), .execAddr(execAddr), .flush(flush),
    .undefDecode(undefDecode), .swiDecode(swiDecode), .coprocInstr(coprocInstr),
    .coprocRegXfer(coprocRegXfer), .coprocNum(coprocNum), .fastInterrupt(fastInterrupt),
    .normalInterrupt(normalInterrupt), .statusWrEn(statusWrEn),
    .statusWrData(statusWrData), .ctrlWrEn(ctrlWrEn), .ctrlWrData(ctrlWrData),
    .accSize(accSize), .addrLow(addrLow), .storeData(storeData), .busData(busData),
    .laneEn(laneEn), .busStoreData(busStoreData), .loadData(loadData),
    .systemResetLowOut(systemResetLowOut), .execHalt(execHalt), .busIdle(busIdle),
    .cancelRegWrite(cancelRegWrite), .cancelBaseWb(cancelBaseWb),
    .restoreBase(restoreBase), .stopXfer(stopXfer), .vectorFetch(vectorFetch),
    .vectorAddr(vectorAddr), .linkWrite(linkWrite), .linkValue(linkValue),
    .savedValue(savedValue), .entryMode(entryMode),
    .currentStatusWord(currentStatusWord), .mmuEnable(mmuEnable),
    .alignEnable(alignEnable), .dcacheEnable(dcacheEnable), .wbufEnable(wbufEnable),
    .icacheEnable(icacheEnable), .bigEndian(bigEndian));

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // drop every request so nothing is taken twice
  task automatic clr();
    {memCycle, mmuAbort, abortReq, fetchValid, execValid, flush, undefDecode, swiDecode,
     coprocInstr, coprocRegXfer, fastInterrupt, normalInterrupt, statusWrEn} = '0;
  endtask

  // request already driven; the answer stands one cycle after it is taken
  task automatic entry(input logic [31:0] vec, input logic [4:0] mode, input bit chain);
    @(negedge clk_sys);
    chk(32'h1, vectorFetch);
    chk(32'h1, linkWrite);
    chk(vec, vectorAddr);
    chk(mode, entryMode);
    chk({27'h0, mode}, currentStatusWord[4:0]);
    clr();
    if (!chain) begin
      @(negedge clk_sys);
      chk(32'h0, vectorFetch);
    end
  endtask

  task automatic none();
    @(negedge clk_sys);
    chk(32'h0, vectorFetch);
    clr();
  endtask

  // supervisor mode with both interrupt masks clear
  task automatic unmask();
    statusWrEn = 1;
    statusWrData = 32'h00000013;
    @(negedge clk_sys);
    statusWrEn = 0;
  endtask

  task automatic dabt(input cxe_xfer_t k, input logic viaMmu, input logic bil);
    {memCycle, baseInList, xferWriteback} = {1'b1, bil, 1'b1};
    xferKind = k;
    {memIsFetch, memInstrAddr, mmuAbort, abortReq} = {1'b0, 32'h100, viaMmu, ~viaMmu};
    #1;
    if (k == XFER_MULTI) begin
      chk(32'h1, stopXfer);
      chk(32'h1, cancelBaseWb);
      chk(bil, restoreBase);
    end else chk(32'h1, cancelRegWrite);
    entry(32'h10, 5'h17, 0);
    chk(32'h108, linkValue);
    chk(32'h1, currentStatusWord[7]);
  endtask

  task automatic mark(input logic [1:0] slot);
    {memCycle, memIsFetch, abortReq, fetchValid, fetchSlot} = {4'hF, slot};
    @(negedge clk_sys);
    clr();
  endtask

  task automatic lane(input cxe_size_t sz, input logic [1:0] a, input logic [3:0] en,
                      input logic [31:0] data);
    {memCycle, addrLow} = {1'b1, a};
    accSize = sz;
    @(negedge clk_sys);
    chk(en, laneEn);
    chk(data, loadData);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog far beyond the 48 cycles the tests need
  initial begin
    #50000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (6) @(negedge clk_sys);
    chk(32'h0, systemResetLowOut);
    chk(32'h1, execHalt);
    chk(32'h1, busIdle);
    rst_n = 1'b1;
    entry(32'h0, 5'h13, 0);
    chk(32'h3, currentStatusWord[7:6]);
    chk(32'h1, systemResetLowOut);
    chk(32'h0, {icacheEnable, bigEndian, wbufEnable, dcacheEnable, alignEnable, mmuEnable});
    $display("test reset done");
    unmask();
    dabt(XFER_SINGLE, 0, 0);
    chk(32'h13, savedValue);
    dabt(XFER_SWAP, 1, 0);
    dabt(XFER_MULTI, 0, 1);
    {mmuAbort, abortReq} = 2'b11;
    none();
    unmask();
    {memCycle, abortReq, fastInterrupt} = 3'b111;
    entry(32'h10, 5'h17, 1);
    entry(32'h1C, 5'h11, 0);
    chk(32'h14, linkValue);
    $display("test data abort done");
    unmask();
    {fastInterrupt, normalInterrupt, execValid, undefDecode} = 4'hF;
    entry(32'h1C, 5'h11, 0);
    unmask();
    {normalInterrupt, execValid, undefDecode} = 3'h7;
    entry(32'h18, 5'h12, 0);
    mark(1);
    {execValid, execSlot, execAddr, undefDecode} = {1'b1, 2'h1, 32'h200, 1'b1};
    entry(32'h0C, 5'h17, 0);
    chk(32'h204, linkValue);
    mark(2);
    {execValid, execSlot, flush} = {1'b1, 2'h2, 1'b1};
    none();
    $display("test prefetch done");
    for (int i = 0; i < 4; i++) begin
      {execValid, execSlot, execAddr} = {1'b1, 2'h0, 32'h300};
      {undefDecode, swiDecode, coprocInstr, coprocRegXfer} = {i == 0, i == 1, i > 1, i == 2};
      coprocNum = (i == 2) ? 4'h3 : 4'hF;
      entry(i == 1 ? 32'h8 : 32'h4, i == 1 ? 5'h13 : 5'h1B, 0);
      chk(32'h304, linkValue);
    end
    {execValid, coprocInstr, coprocRegXfer, coprocNum} = 7'h7F;
    none();
    storeData = 32'h00005AA5;
    {ctrlWrEn, ctrlWrData} = {1'b1, 16'h108F};
    @(negedge clk_sys);
    ctrlWrEn = 0;
    chk(32'h3F, {icacheEnable, bigEndian, wbufEnable, dcacheEnable, alignEnable, mmuEnable});
    lane(SZ_BYTE, 2'h0, 4'h8, 32'hC3);
    chk(32'hA5A5A5A5, busStoreData);
    lane(SZ_HALF, 2'h0, 4'hC, 32'hC3B2);
    chk(32'h5AA55AA5, busStoreData);
    lane(SZ_WORD, 2'h0, 4'hF, 32'hC3B2A190);
    chk(32'h00005AA5, busStoreData);
    lane(SZ_FETCH, 2'h0, 4'hF, 32'hC3B2A190);
    {ctrlWrEn, ctrlWrData} = {1'b1, 16'h0000};
    @(negedge clk_sys);
    ctrlWrEn = 0;
    lane(SZ_BYTE, 2'h0, 4'h1, 32'h90);
    lane(SZ_HALF, 2'h2, 4'hC, 32'hC3B2);
    clr();
    $display("test lanes done");
    stop_test();
  end
endmodule
`default_nettype wire

// File: tb/cxe_mem_model.sv
/*
  far side model: memory read data and the external abort source.
  assumes the bench raises abortReq only where a scenario wants an abort.
*/
`timescale 1ns/1ps
`default_nettype none
module cxe_mem_model (
  // bus side
  input wire logic clk_sys,
  input wire logic memCycle,
  input wire logic abortReq,
  // answers
  output logic extAbort,
  output logic [31:0] busData
);
  logic [31:0] filler = 32'h0;
  // abort is signalled only inside a memory access cycle
  assign extAbort = memCycle & abortReq;
  // released bus shows a changing pattern, never stale data
  always_ff @(posedge clk_sys) filler <= ~filler ^ 32'h5A5A5A5A;
  assign busData = memCycle ? 32'hC3B2A190 : filler;
endmodule
`default_nettype wire
